// File: verilog/ooc_on_off_ctrl.sv
// on/off and margin control with a byte command slave on the bus pins
`timescale 1ns/1ps
module ooc_on_off_ctrl #(
   parameter logic [6:0] DEV_ADDR = ooc_pkg::DEV_ADDR_DFLT
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic pmb_scl,
   input wire logic pmb_sda_i,
   output logic pmb_sda_o,
   output logic pmb_sda_oe,
   input wire logic ctrl_pin,
   input wire logic pwr_ok,
   input wire logic vout_fault,
   output ooc_pkg::ooc_ctrl_t conv_ctrl
);
   ooc_pkg::ooc_state_t q;
   ooc_pkg::ooc_state_t d;
   ooc_pkg::ooc_lnk_t lnk_q;
   ooc_pkg::ooc_lnk_t lnk_d;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic pin_on;
   logic bus_on;
   logic run_c;
   logic fast_c;
   logic [1:0] mrg_c;
   logic [7:0] rx_byte;

   // known control byte codes
   function automatic logic known_cmd(input logic [7:0] c);
      return (c == ooc_pkg::CMD_OP) || (c == ooc_pkg::CMD_CFG);
   endfunction

   // read-back value for a command code
   function automatic logic [7:0] reg_read(input logic [7:0] c, input logic [7:0] op,
                                           input logic [7:0] cfg);
      if (c == ooc_pkg::CMD_OP) return op;
      if (c == ooc_pkg::CMD_CFG) return cfg;
      return 8'h00;
   endfunction

   // field extraction from the command byte
   function automatic logic [1:0] op_en(input logic [7:0] op);
      return op[ooc_pkg::OP_EN_HI:ooc_pkg::OP_EN_LO];
   endfunction

   function automatic logic [1:0] op_mrg(input logic [7:0] op);
      return op[ooc_pkg::OP_MRG_HI:ooc_pkg::OP_MRG_LO];
   endfunction

   function automatic logic [1:0] op_flt(input logic [7:0] op);
      return op[ooc_pkg::OP_FLT_HI:ooc_pkg::OP_FLT_LO];
   endfunction

   // bus clock domain: sample data on each rising bus clock edge
   always_comb begin
      lnk_d.shift = {lnk_q.shift[6:0], pmb_sda_i};
   end

   always_ff @(posedge pmb_scl) begin
      lnk_q <= lnk_d;
   end

   // byte is read only at a synced falling edge, while the shifter stands still
   assign rx_byte = lnk_q.shift;

   // bus events seen through the synchronisers
   assign scl_rise = q.scl_s & ~q.scl_p;
   assign scl_fall = ~q.scl_s & q.scl_p;
   assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop_c = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

   // run decision from the enabled sources
   always_comb begin
      pin_on = q.cfg[ooc_pkg::CFG_POL] ? q.pin_s : ~q.pin_s;
      bus_on = (op_en(q.op) == ooc_pkg::EN_ON);
      // each enabled source must ask for run, disabled ones pass
      run_c = pwr_ok & (~q.cfg[ooc_pkg::CFG_PWRUP] |
         ((~q.cfg[ooc_pkg::CFG_BUS] | bus_on) &
         (~q.cfg[ooc_pkg::CFG_PIN] | pin_on)));
      // immediate off from the bus field or the pin with fast action
      fast_c = ~pwr_ok | (q.cfg[ooc_pkg::CFG_PWRUP] &
         ((q.cfg[ooc_pkg::CFG_BUS] & (op_en(q.op) == ooc_pkg::EN_IMM)) |
         (q.cfg[ooc_pkg::CFG_PIN] & ~pin_on & q.cfg[ooc_pkg::CFG_FAST])));
      // reserved margin code falls back to nominal
      mrg_c = (op_mrg(q.op) == 2'h3) ? ooc_pkg::MRG_NOM : op_mrg(q.op);
   end

   // next state of the whole system clock side
   always_comb begin
      d = q;
      d.scl_m = pmb_scl;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = pmb_sda_i;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.pin_m = ctrl_pin;
      d.pin_s = q.pin_m;
      d.ctrl.run = run_c;
      d.ctrl.fast_off = ~run_c & fast_c;
      d.ctrl.margin = mrg_c;
      // faults gated whenever margined and the fault field is not set to act
      d.ctrl.fault_act = vout_fault & ((mrg_c == ooc_pkg::MRG_NOM) |
         (op_flt(q.op) == ooc_pkg::FLT_ACT));
      if (start_c) begin
         d.st = ooc_pkg::ST_ADDR;
         d.bitcnt = 4'h0;
         d.sda_oe = 1'b0;
      end else if (stop_c) begin
         d.st = ooc_pkg::ST_IDLE;
         d.sda_oe = 1'b0;
      end else if (q.st != ooc_pkg::ST_IDLE) begin
         if (scl_rise) begin
            d.bitcnt = q.bitcnt + 4'h1;
            // master acknowledge after a read byte
            if (q.st == ooc_pkg::ST_TX && q.bitcnt == ooc_pkg::BYTE_BITS) begin
               d.nack = q.sda_s;
            end
         end else if (scl_fall) begin
            if (q.bitcnt == ooc_pkg::BYTE_BITS) begin
               d.sda_oe = 1'b0;
               unique case (q.st)
                  ooc_pkg::ST_ADDR: begin
                     if (rx_byte[7:1] == DEV_ADDR) begin
                        d.sda_oe = 1'b1;
                        d.nack = 1'b0;
                        d.tx = reg_read(q.cmd, q.op, q.cfg);
                        d.st = rx_byte[0] ? ooc_pkg::ST_TX : ooc_pkg::ST_CMD;
                     end else begin
                        d.st = ooc_pkg::ST_IDLE;
                     end
                  end
                  ooc_pkg::ST_CMD: begin
                     d.cmd = rx_byte;
                     d.sda_oe = known_cmd(rx_byte);
                     d.st = known_cmd(rx_byte) ? ooc_pkg::ST_DATA : ooc_pkg::ST_IDLE;
                  end
                  ooc_pkg::ST_DATA: begin
                     d.sda_oe = 1'b1;
                     if (q.cmd == ooc_pkg::CMD_OP) begin
                        d.op = rx_byte;
                     end
                     if (q.cmd == ooc_pkg::CMD_CFG) begin
                        d.cfg = rx_byte;
                     end
                  end
                  ooc_pkg::ST_TX: begin
                     d.sda_oe = 1'b0;
                  end
                  default: begin
                     d.st = ooc_pkg::ST_IDLE;
                  end
               endcase
            end else if (q.bitcnt == ooc_pkg::ACK_BIT) begin
               // end of acknowledge slot
               d.bitcnt = 4'h0;
               d.sda_oe = 1'b0;
               if (q.st == ooc_pkg::ST_TX) begin
                  if (q.nack) begin
                     d.st = ooc_pkg::ST_IDLE;
                  end else begin
                     d.sda_oe = ~q.tx[7];
                  end
               end
            end else if (q.st == ooc_pkg::ST_TX) begin
               // open drain: pull low for a zero bit
               d.sda_oe = ~q.tx[3'(4'h7 - q.bitcnt)];
            end
         end
      end
   end

   // system clock register with synchronous reset
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= '0;
         q.st <= ooc_pkg::ST_IDLE;
         q.op <= ooc_pkg::OP_RST;
         q.cfg <= ooc_pkg::CFG_RST;
         q.scl_m <= 1'b1;
         q.scl_s <= 1'b1;
         q.scl_p <= 1'b1;
         q.sda_m <= 1'b1;
         q.sda_s <= 1'b1;
         q.sda_p <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs
   assign pmb_sda_o = 1'b0;
   assign pmb_sda_oe = q.sda_oe;
   assign conv_ctrl = q.ctrl;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence s_ctl_bus_only;
      q.cfg[4] && q.cfg[3] && !q.cfg[2];
   endsequence

   sequence s_data_done;
      q.st == ooc_pkg::ST_DATA && scl_fall && q.bitcnt == ooc_pkg::BYTE_BITS
         && !start_c && !stop_c;
   endsequence

   AST_IMM_OFF: assert property (s_ctl_bus_only ##0 (q.op[7:6] == 2'h0)
      |=> !conv_ctrl.run && conv_ctrl.fast_off)
      else $error("immediate off not applied");
   AST_SOFT_OFF: assert property (s_ctl_bus_only ##0 (q.op[7:6] == 2'h1) && pwr_ok
      |=> !conv_ctrl.run && !conv_ctrl.fast_off)
      else $error("soft off not sequenced");
   AST_BUS_ON: assert property (s_ctl_bus_only ##0 (q.op[7:6] == 2'h2) && pwr_ok
      |=> conv_ctrl.run)
      else $error("bus enable did not start output");
   AST_MARGIN_HIGH: assert property (q.op[5:4] == 2'h2 |=> conv_ctrl.margin == 2'h2)
      else $error("margin high not selected");
   AST_FLT_IGNORE: assert property (q.op[5:4] == 2'h1 && q.op[3:2] == 2'h1
      |=> !conv_ctrl.fault_act)
      else $error("fault acted on while ignored");
   AST_FLT_ACT: assert property (q.op[5:4] == 2'h2 && q.op[3:2] == 2'h2 && vout_fault
      |=> conv_ctrl.fault_act)
      else $error("fault not acted on");
   AST_ALWAYS_ON: assert property (pwr_ok && !q.cfg[4] |=> conv_ctrl.run)
      else $error("output not running with power present");
   AST_BUS_IGNORED: assert property (pwr_ok && q.cfg[4] && !q.cfg[3] && !q.cfg[2]
      |=> conv_ctrl.run)
      else $error("bus field not ignored");
   AST_PIN_OFF: assert property (q.cfg[4] && q.cfg[2] && (q.pin_s != q.cfg[1])
      |=> !conv_ctrl.run)
      else $error("pin deasserted but output runs");
   AST_PIN_FAST: assert property (q.cfg[4] && q.cfg[2] && q.cfg[0] && (q.pin_s != q.cfg[1])
      |=> conv_ctrl.fast_off)
      else $error("pin off not immediate");
   AST_PIN_SOFT: assert property (pwr_ok && q.cfg[4] && !q.cfg[3] && !q.cfg[0]
      |=> !conv_ctrl.fast_off)
      else $error("pin off not sequenced");
   AST_OP_WRITE: assert property (s_data_done ##0 q.cmd == ooc_pkg::CMD_OP
      |=> q.op == $past(rx_byte))
      else $error("command byte write lost");
   // pin at its asserted level of either polarity starts the output
   AST_PIN_ON: assert property (pwr_ok && q.cfg[4] && !q.cfg[3] && q.cfg[2]
      && (q.pin_s == q.cfg[1]) |=> conv_ctrl.run)
      else $error("asserted pin did not start output");
   // pin asks to run but the bus field does not: both sources must agree
   AST_AND_SOURCES: assert property (q.cfg[4] && q.cfg[3] && q.cfg[2]
      && (q.pin_s == q.cfg[1]) && (q.op[7:6] != 2'h2) |=> !conv_ctrl.run)
      else $error("output runs without every enabled source");
endmodule // ooc_on_off_ctrl

// File: common/ooc_pkg.sv
// shared constants and types for the output on/off and margin controller
package ooc_pkg;
   // command codes of the two control bytes
   localparam logic [7:0] CMD_OP = 8'h01;
   localparam logic [7:0] CMD_CFG = 8'h02;
   // reset values of the two control bytes
   localparam logic [7:0] OP_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   // bus address of this device, value arbitrary
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h40;
   // command byte field positions
   localparam int OP_EN_HI = 7;
   localparam int OP_EN_LO = 6;
   localparam int OP_MRG_HI = 5;
   localparam int OP_MRG_LO = 4;
   localparam int OP_FLT_HI = 3;
   localparam int OP_FLT_LO = 2;
   // config byte bit positions
   localparam int CFG_PWRUP = 4;
   localparam int CFG_BUS = 3;
   localparam int CFG_PIN = 2;
   localparam int CFG_POL = 1;
   localparam int CFG_FAST = 0;
   // field encodings
   localparam logic [1:0] EN_IMM = 2'h0;
   localparam logic [1:0] EN_SOFT = 2'h1;
   localparam logic [1:0] EN_ON = 2'h2;
   localparam logic [1:0] MRG_NOM = 2'h0;
   localparam logic [1:0] MRG_LOW = 2'h1;
   localparam logic [1:0] MRG_HIGH = 2'h2;
   localparam logic [1:0] FLT_IGNORE = 2'h1;
   localparam logic [1:0] FLT_ACT = 2'h2;
   // bit counter marks within one byte slot
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] ACK_BIT = 4'h9;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD = 3'b010,
      ST_DATA = 3'b011,
      ST_TX = 3'b100
   } ooc_bus_st_t;

   // converter control outputs
   typedef struct packed {
      logic run;
      logic fast_off;
      logic [1:0] margin;
      logic fault_act;
   } ooc_ctrl_t;

   // system clock state
   typedef struct packed {
      ooc_bus_st_t st;
      logic [3:0] bitcnt;
      logic [7:0] cmd;
      logic [7:0] op;
      logic [7:0] cfg;
      logic [7:0] tx;
      logic nack;
      logic sda_oe;
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic pin_m;
      logic pin_s;
      ooc_ctrl_t ctrl;
   } ooc_state_t;

   // bus clock state
   typedef struct packed {
      logic [7:0] shift;
   } ooc_lnk_t;
endpackage

// File: test/ooc_host_model.sv
// bus host model driving the clock and open-drain data pins
`timescale 1ns/1ps
module ooc_host_model (
   input wire logic lclk,
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   // idle bus: clock high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // wait a number of link clocks
   task automatic tick(input int n);
      repeat (n) @(posedge lclk);
   endtask
   // one pulse: data set mid-low, held to the fall, line sampled while high
   task automatic bit_io(input logic b, output logic s);
      tick(3);
      sda_pull <= !b;
      tick(3);
      scl <= 1'b1;
      tick(3);
      s = sda;
      tick(3);
      scl <= 1'b0;
   endtask
   // start or repeated start: data falls while clock high
   task automatic start();
      tick(3);
      sda_pull <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sda_pull <= 1'b1;
      tick(3);
      scl <= 1'b0;
   endtask
   // stop: data rises while clock high, then the clock stands still
   task automatic stop();
      tick(3);
      sda_pull <= 1'b1;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sda_pull <= 1'b0;
      tick(6);
   endtask
   // eight bits msb first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, input logic ak_in, output logic [7:0] rx,
      output logic ak);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ak_in, ak);
   endtask
endmodule // ooc_host_model

// File: test/tb_top.sv
// self-checking bench for the on/off and margin controller
`timescale 1ns/1ps
module tb_top;
   logic clk_sys, lclk, sys_rst, pwr_ok, ctrl_pin, vout_fault, scl, sda_pull, sda_o, sda_oe;
   logic sda, chk;
   logic [7:0] op, cfg;
   ooc_pkg::ooc_ctrl_t ctrl;
   ooc_pkg::ooc_ctrl_t exp_q[$];
   int fails, n_compared, cyc;
   integer seed;
   // open-drain data line with pull-up
   assign sda = !(sda_pull | (sda_oe & !sda_o));
   // system clock and unrelated link clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = !clk_sys;
   end
   initial begin
      lclk = 1'b0;
      #7;
      forever #24 lclk = !lclk;
   end
   ooc_on_off_ctrl ooc_on_off_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .pmb_scl(scl),
      .pmb_sda_i(sda), .pmb_sda_o(sda_o), .pmb_sda_oe(sda_oe), .ctrl_pin(ctrl_pin),
      .pwr_ok(pwr_ok), .vout_fault(vout_fault), .conv_ctrl(ctrl));
   ooc_host_model ooc_host_model_inst (.lclk(lclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
   task automatic check(input logic [7:0] seen, input logic [7:0] want_v, input string m);
      n_compared++;
      if (seen !== want_v) begin
         fails++;
         $display("BAD %0t %s seen %h want %h", $time, m, seen, want_v);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // expected converter controls
   function automatic ooc_pkg::ooc_ctrl_t want(input logic [7:0] o, input logic [7:0] c,
      input logic p, input logic pin, input logic f);
      ooc_pkg::ooc_ctrl_t r;
      logic pin_on, bus_on;
      pin_on = c[1] ? pin : !pin;
      bus_on = o[7:6] == ooc_pkg::EN_ON;
      r.run = p & (!c[4] | ((!c[3] | bus_on) & (!c[2] | pin_on)));
      r.fast_off = !r.run & (!p | c[4] & ((c[3] & o[7:6] == 2'h0) | (c[2] & !pin_on & c[0])));
      r.margin = (o[5:4] == 2'h3) ? 2'h0 : o[5:4];
      r.fault_act = f & (r.margin == 2'h0 | o[3:2] == 2'h2);
      return r;
   endfunction
   task automatic bus_write(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
      input logic [2:0] nak);
      logic [7:0] rx;
      logic [2:0] got;
      ooc_host_model_inst.start();
      ooc_host_model_inst.byte_io({a, 1'b0}, 1'b1, rx, got[2]);
      ooc_host_model_inst.byte_io(c, 1'b1, rx, got[1]);
      ooc_host_model_inst.byte_io(d, 1'b1, rx, got[0]);
      ooc_host_model_inst.stop();
      check({5'h0, got}, {5'h0, nak}, "ack");
   endtask
   task automatic bus_read(input logic [7:0] c, input logic [7:0] want_b);
      logic [7:0] rx;
      logic ak;
      ooc_host_model_inst.start();
      ooc_host_model_inst.byte_io({ooc_pkg::DEV_ADDR_DFLT, 1'b0}, 1'b1, rx, ak);
      ooc_host_model_inst.byte_io(c, 1'b1, rx, ak);
      ooc_host_model_inst.start();
      ooc_host_model_inst.byte_io({ooc_pkg::DEV_ADDR_DFLT, 1'b1}, 1'b1, rx, ak);
      ooc_host_model_inst.byte_io(8'hff, 1'b1, rx, ak);
      ooc_host_model_inst.stop();
      check(rx, want_b, "read");
   endtask
   // set the side inputs, let them settle, note the expected controls
   task automatic expect_now(input logic p, input logic pin, input logic f);
      @(posedge clk_sys);
      pwr_ok <= p;
      ctrl_pin <= pin;
      vout_fault <= f;
      repeat (5) @(posedge clk_sys);
      exp_q.push_back(want(op, cfg, p, pin, f));
      chk <= 1'b1;
      @(posedge clk_sys);
      chk <= 1'b0;
   endtask
   // compare the controls with the oldest note mid-cycle, when settled
   always @(negedge clk_sys) begin
      if (chk) begin
         check({3'h0, ctrl}, {3'h0, exp_q.pop_front()}, "ctrl");
      end
   end
   // hang limit
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         give_verdict();
      end
   end
   // main sequence
   initial begin
      seed = 32'h47aa84ef;
      sys_rst = 1'b1;
      pwr_ok = 1'b1;
      ctrl_pin = 1'b0;
      vout_fault = 1'b0;
      chk = 1'b0;
      op = 8'h00;
      cfg = 8'h00;
      fails = 0;
      n_compared = 0;
      cyc = 0;
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      expect_now(1'b1, 1'b0, 1'b1);
      bus_read(ooc_pkg::CMD_OP, 8'h00);
      bus_read(ooc_pkg::CMD_CFG, 8'h00);
      for (int i = 0; i < 32; i++) begin
         cfg = 8'($random(seed)) & 8'h1f;
         op = {i[1:0], i[3:2], 2'($random(seed)), 2'h0};
         bus_write(ooc_pkg::DEV_ADDR_DFLT, ooc_pkg::CMD_CFG, cfg, 3'h0);
         bus_write(ooc_pkg::DEV_ADDR_DFLT, ooc_pkg::CMD_OP, op, 3'h0);
         for (int k = 0; k < 8; k++) begin
            expect_now(k[0], k[1], k[2]);
         end
      end
      bus_read(ooc_pkg::CMD_CFG, cfg);
      // bus-only control: every enable code, margined fault handling
      cfg = 8'h18;
      bus_write(ooc_pkg::DEV_ADDR_DFLT, ooc_pkg::CMD_CFG, cfg, 3'h0);
      for (int j = 0; j < 4; j++) begin
         op = {j[1:0], 2'(j + 1), 2'(j + 1), 2'h0};
         bus_write(ooc_pkg::DEV_ADDR_DFLT, ooc_pkg::CMD_OP, op, 3'h0);
         expect_now(1'b1, 1'b0, 1'b1);
      end
      // unknown command reads back as zero
      bus_read(8'h03, 8'h00);
      bus_write(ooc_pkg::DEV_ADDR_DFLT ^ 7'h01, ooc_pkg::CMD_OP, ~op, 3'h7);
      bus_write(ooc_pkg::DEV_ADDR_DFLT, 8'h03, ~op, 3'h3);
      bus_read(ooc_pkg::CMD_OP, op);
      expect_now(1'b1, 1'b1, 1'b1);
      // mid-run reset: both control bytes back to defaults
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      op = ooc_pkg::OP_RST;
      cfg = ooc_pkg::CFG_RST;
      repeat (3) @(posedge clk_sys);
      expect_now(1'b1, 1'b0, 1'b0);
      bus_read(ooc_pkg::CMD_OP, ooc_pkg::OP_RST);
      give_verdict();
   end
endmodule // tb_top
